// ---- common/core_pkg.sv ----
// Purpose: shared types and constants of the instruction timing core
// Assumes: single clock domain, synchronous reset
// Notes: opcode constants name the few encodings the checks lean on
package core_pkg;

	localparam int MAX_CYCLES = 8;

	localparam int FLAG_CY = 7;
	localparam int FLAG_AC = 6;
	localparam int FLAG_OV = 2;
	localparam int FLAG_P = 0;

	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] B_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] DPP_RESET = 16'h0000;

	localparam logic [7:0] OP_DIV = 8'h84;
	localparam logic [7:0] OP_MUL = 8'hA4;
	localparam logic [7:0] OP_JZ = 8'h60;
	localparam logic [7:0] OP_ADD_IMM = 8'h24;
	localparam logic [7:0] OP_ADD_DIR = 8'h25;
	localparam logic [7:0] OP_ANL_IND = 8'h56;
	localparam logic [7:0] OP_ORL_DIR_IMM = 8'h43;
	localparam logic [7:0] OP_XRL_DIR_A = 8'h62;

	typedef struct packed {
		logic [1:0] bytes;
		logic [3:0] cycles;
		logic cond;
	} timing_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] b;
		logic [7:0] status;
	} arch_t;

	typedef enum logic [4:0] {
		ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_ORL, ALU_ANL, ALU_XRL, ALU_MOV,
		ALU_INC, ALU_DEC, ALU_DIV, ALU_MUL, ALU_SWAP, ALU_DA, ALU_CLR, ALU_CPL,
		ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INCDP, ALU_CPLC, ALU_CLRC, ALU_SETBC,
		ALU_ORLC, ALU_ANLC, ALU_ORLNC, ALU_ANLNC, ALU_MOVC, ALU_CJNE
	} alu_op_t;

endpackage : core_pkg

// ---- sim/pipelined_core_instruction_timing_tb.sv ----
// Purpose: self-checking bench for the instruction timing core
// Assumes: inputs change at the falling edge; state commits at the take edge
// Notes: integer reference model of accumulator, auxiliary register and flags
`timescale 1ns/1ps
module pipelined_core_instruction_timing_tb;
	logic clk, srst, op_valid, branch_taken, op_ready, done, clk_hold;
	logic [7:0] op_byte, operand, acc, b_value, program_status_word;
	logic [3:0] cycles_taken;
	logic [1:0] bytes_taken;
	logic [15:0] data_pointer_pair;
	logic [5:0] idx;
	logic [23:0] ent;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int a, b, cy, ac, ov, dp, s, k, j;

	core_timing i_core_timing (.clk(clk), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
		.operand(operand), .branch_taken(branch_taken), .op_ready(op_ready), .done(done),
		.cycles_taken(cycles_taken), .bytes_taken(bytes_taken), .acc(acc), .b_value(b_value),
		.program_status_word(program_status_word), .data_pointer_pair(data_pointer_pair));
	prog_mem i_prog_mem (.idx(idx), .ent(ent));

	initial begin
		clk = 1'b0;
		clk_hold = 1'b0;
		forever begin
			#12.5;
			if (!clk_hold) clk = ~clk;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
	end

	task automatic chk_time(input string name, input int exp, input logic [3:0] got);
		n_compared++;
		if (got !== 4'(exp)) begin
			err_total++;
			$display("BAD %s exp %0d got %0d", name, exp, got);
		end
	endtask : chk_time

	task automatic chk_state(input string name, input int exp, input logic [15:0] got);
		n_compared++;
		if (got !== 16'(exp)) begin
			err_total++;
			$display("BAD %s exp %0h got %0h", name, exp, got);
		end
	endtask : chk_state

	task automatic model(input int kind, input int o);
		case (kind)
			1, 2: begin
				k = (kind == 2) ? cy : 0;
				s = a + o + k;
				ac = ((a & 15) + (o & 15) + k) > 15;
				ov = ((a ^ s) & (o ^ s) & 128) != 0;
				cy = s > 255;
				a = s & 255;
			end
			3: begin
				s = (a - o - cy) & 255;
				ac = (a & 15) < (o & 15) + cy;
				ov = ((a ^ o) & (a ^ s) & 128) != 0;
				cy = a < o + cy;
				a = s;
			end
			4: a = a & o;
			5: a = a | o;
			6: a = a ^ o;
			7: a = o;
			8: a = (a + 1) & 255;
			9: a = (a + 255) & 255;
			10: begin
				s = a * b;
				a = s & 255;
				b = s >> 8;
				cy = 0;
				ov = s > 255;
			end
			11: begin
				cy = 0;
				ov = b == 0;
				if (b != 0) begin
					s = a;
					a = s / b;
					b = s % b;
				end
			end
			12: cy = 0;
			13: cy = 1;
			14: cy = a < o;
			15: dp = (dp + 1) & 65535;
			default: ;
		endcase
	endtask : model

	task automatic model_reset();
		a = 0;
		b = 0;
		cy = 0;
		ac = 0;
		ov = 0;
		dp = 0;
	endtask : model_reset

	task automatic chk_reset();
		chk_time("ready_rst", 1, {3'h0, op_ready});
		chk_time("done_rst", 0, {3'h0, done});
		chk_time("cycles_rst", 0, cycles_taken);
		chk_state("acc_rst", 0, {8'h00, acc});
		chk_state("b_rst", 0, {8'h00, b_value});
		chk_state("status_rst", 0, {8'h00, program_status_word});
		chk_state("pointer_rst", 0, data_pointer_pair);
		chk_time("bytes_rst", 0, {2'h0, bytes_taken});
	endtask : chk_reset

	// offer one instruction at a falling edge, wait for done, compare against the model
	task automatic run(input logic [5:0] i, input logic [7:0] o, input logic t, input bit stall);
		int n, e;
		idx = i;
		#1;
		op_valid = 1'b1;
		op_byte = ent[23:16];
		operand = o;
		branch_taken = t;
		chk_time("ready", 1, {3'h0, op_ready});
		e = ent[11:8] + (ent[7:4] != 0 && t);
		model(ent[3:0], o);
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (stall && n == 1) begin
				clk_hold = 1'b1;
				// not a multiple of the half period, so no toggle races the release
				#1010;
				clk_hold = 1'b0;
			end
			if (done !== 1'b1) begin
				chk_time("ready_busy", 0, {3'h0, op_ready});
				// junk offered while busy must be refused
				op_byte = 8'($urandom);
				operand = 8'($urandom);
			end
		end while (done !== 1'b1 && n < 12);
		chk_time("cycles", e, 4'(n));
		chk_time("cycles_taken", e, cycles_taken);
		chk_time("bytes", ent[15:12], {2'h0, bytes_taken});
		chk_time("ready_done", 1, {3'h0, op_ready});
		chk_state("acc", a, {8'h00, acc});
		chk_state("b", b, {8'h00, b_value});
		chk_state("status", cy * 128 + ac * 64 + ov * 4 + $countones(8'(a)) % 2,
			{8'h00, program_status_word});
		chk_state("pointer", dp, data_pointer_pair);
	endtask : run

	task automatic results();
		if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	initial begin
		srst = 1'b1;
		op_valid = 1'b0;
		op_byte = 8'h00;
		operand = 8'h00;
		branch_taken = 1'b0;
		idx = 6'h00;
		model_reset();
		void'($urandom(9937));
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk_reset();
		for (j = 0; j < 37; j++) run(6'(j), 8'($urandom), 1'b0, 1'b0);
		for (j = 30; j < 33; j++) run(6'(j), 8'($urandom), 1'b1, 1'b0);
		run(6'h1A, 8'h00, 1'b0, 1'b1);
		repeat (300) run(6'($urandom % 37), 8'($urandom), 1'($urandom), 1'b0);
		// reset in the middle of a divide
		idx = 6'h1A;
		#1;
		op_byte = ent[23:16];
		repeat (3) @(negedge clk);
		srst = 1'b1;
		op_valid = 1'b0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		model_reset();
		chk_reset();
		run(6'h03, 8'h7F, 1'b0, 1'b0);
		run(6'h1B, 8'h00, 1'b0, 1'b0);
		results();
	end
endmodule : pipelined_core_instruction_timing_tb

// ---- sim/prog_mem.sv ----
// Purpose: program store model that hands the core one instruction at a time
// Assumes: each entry packs opcode, bytes, clocks, branch flag and effect kind as hex digits
// Notes: effect kinds are decoded by the bench reference model
`timescale 1ns/1ps
module prog_mem (
	input wire logic [5:0] idx,
	output logic [23:0] ent
);
	always_comb begin
		case (idx)
			6'h00: ent = 24'h281101;
			6'h01: ent = 24'h252201;
			6'h02: ent = 24'h261201;
			6'h03: ent = 24'h242201;
			6'h04: ent = 24'h381102;
			6'h05: ent = 24'h352202;
			6'h06: ent = 24'h361202;
			6'h07: ent = 24'h342202;
			6'h08: ent = 24'h981103;
			6'h09: ent = 24'h952203;
			6'h0A: ent = 24'h961203;
			6'h0B: ent = 24'h942203;
			6'h0C: ent = 24'h581104;
			6'h0D: ent = 24'h552204;
			6'h0E: ent = 24'h561204;
			6'h0F: ent = 24'h542204;
			6'h10: ent = 24'h481105;
			6'h11: ent = 24'h452205;
			6'h12: ent = 24'h461205;
			6'h13: ent = 24'h442205;
			6'h14: ent = 24'h522200;
			6'h15: ent = 24'h533300;
			6'h16: ent = 24'h422200;
			6'h17: ent = 24'h433300;
			6'h18: ent = 24'h622200;
			6'h19: ent = 24'hA4140A;
			6'h1A: ent = 24'h84180B;
			6'h1B: ent = 24'h041108;
			6'h1C: ent = 24'h141109;
			6'h1D: ent = 24'hA3110F;
			6'h1E: ent = 24'h602210;
			6'h1F: ent = 24'h702210;
			6'h20: ent = 24'hB4331E;
			6'h21: ent = 24'h742207;
			6'h22: ent = 24'hC3110C;
			6'h23: ent = 24'hD3110D;
			default: ent = 24'h642206;
		endcase
	end
endmodule : prog_mem

// ---- verilog/core_alu.sv ----
// Purpose: accumulator, auxiliary register and status word update
// Assumes: operand holds the source byte or bit of the instruction
// Notes: purely combinational; the caller commits the result
`timescale 1ns/1ps
module core_alu (
	input wire core_pkg::alu_op_t op,
	input wire core_pkg::arch_t cur,
	input wire logic [7:0] operand,
	input wire logic [15:0] pointer,
	output core_pkg::arch_t nxt,
	output logic [15:0] pointer_next
);

	logic [7:0] a;
	logic cy_in;
	logic ac_in;
	logic carry_in;
	logic [8:0] add_full;
	logic [4:0] add_nib;
	logic [7:0] add_low;
	logic [8:0] sub_full;
	logic [4:0] sub_nib;
	logic sub_ov;
	logic lo_fix;
	logic [8:0] da1;
	logic hi_fix;
	logic [8:0] da2;
	logic [15:0] prod;
	logic b_zero;
	logic [7:0] quot;
	logic [7:0] rem;

	assign a = cur.acc;
	assign cy_in = cur.status[core_pkg::FLAG_CY];
	assign ac_in = cur.status[core_pkg::FLAG_AC];
	assign carry_in = (op == core_pkg::ALU_ADDC) ? cy_in : 1'b0;
	assign add_full = {1'b0, a} + {1'b0, operand} + {8'h00, carry_in};
	assign add_nib = {1'b0, a[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
	assign add_low = {1'b0, a[6:0]} + {1'b0, operand[6:0]} + {7'h00, carry_in};
	assign sub_full = {1'b0, a} - {1'b0, operand} - {8'h00, cy_in};
	assign sub_nib = {1'b0, a[3:0]} - {1'b0, operand[3:0]} - {4'h0, cy_in};
	assign sub_ov = (a[7] ^ operand[7]) & (sub_full[7] ^ a[7]);
	assign lo_fix = (a[3:0] > 4'h9) || ac_in;
	assign da1 = {1'b0, a} + (lo_fix ? 9'h006 : 9'h000);
	assign hi_fix = (da1[7:4] > 4'h9) || da1[8] || cy_in;
	assign da2 = da1 + (hi_fix ? 9'h060 : 9'h000);
	assign prod = {8'h00, a} * {8'h00, cur.b};
	assign b_zero = (cur.b == 8'h00);
	// divide by zero leaves both registers alone and raises overflow
	assign quot = b_zero ? a : a / cur.b;
	assign rem = b_zero ? cur.b : a % cur.b;

	always_comb begin
		nxt = cur;
		pointer_next = pointer;
		case (op)
			core_pkg::ALU_ADD, core_pkg::ALU_ADDC: begin
				nxt.acc = add_full[7:0];
				nxt.status[core_pkg::FLAG_CY] = add_full[8];
				nxt.status[core_pkg::FLAG_AC] = add_nib[4];
				nxt.status[core_pkg::FLAG_OV] = add_full[8] ^ add_low[7];
			end
			core_pkg::ALU_SUBB: begin
				nxt.acc = sub_full[7:0];
				nxt.status[core_pkg::FLAG_CY] = sub_full[8];
				nxt.status[core_pkg::FLAG_AC] = sub_nib[4];
				nxt.status[core_pkg::FLAG_OV] = sub_ov;
			end
			core_pkg::ALU_ORL: nxt.acc = a | operand;
			core_pkg::ALU_ANL: nxt.acc = a & operand;
			core_pkg::ALU_XRL: nxt.acc = a ^ operand;
			core_pkg::ALU_MOV: nxt.acc = operand;
			core_pkg::ALU_INC: nxt.acc = a + 8'h01;
			core_pkg::ALU_DEC: nxt.acc = a - 8'h01;
			core_pkg::ALU_DIV: begin
				nxt.acc = quot;
				nxt.b = rem;
				nxt.status[core_pkg::FLAG_CY] = 1'b0;
				nxt.status[core_pkg::FLAG_OV] = b_zero;
			end
			core_pkg::ALU_MUL: begin
				nxt.acc = prod[7:0];
				nxt.b = prod[15:8];
				nxt.status[core_pkg::FLAG_CY] = 1'b0;
				nxt.status[core_pkg::FLAG_OV] = (prod[15:8] != 8'h00);
			end
			core_pkg::ALU_SWAP: nxt.acc = {a[3:0], a[7:4]};
			core_pkg::ALU_DA: begin
				nxt.acc = da2[7:0];
				nxt.status[core_pkg::FLAG_CY] = cy_in | da1[8] | da2[8];
			end
			core_pkg::ALU_CLR: nxt.acc = 8'h00;
			core_pkg::ALU_CPL: nxt.acc = ~a;
			core_pkg::ALU_RR: nxt.acc = {a[0], a[7:1]};
			core_pkg::ALU_RL: nxt.acc = {a[6:0], a[7]};
			core_pkg::ALU_RRC: begin
				nxt.acc = {cy_in, a[7:1]};
				nxt.status[core_pkg::FLAG_CY] = a[0];
			end
			core_pkg::ALU_RLC: begin
				nxt.acc = {a[6:0], cy_in};
				nxt.status[core_pkg::FLAG_CY] = a[7];
			end
			core_pkg::ALU_INCDP: pointer_next = pointer + 16'h0001;
			core_pkg::ALU_CPLC: nxt.status[core_pkg::FLAG_CY] = ~cy_in;
			core_pkg::ALU_CLRC: nxt.status[core_pkg::FLAG_CY] = 1'b0;
			core_pkg::ALU_SETBC: nxt.status[core_pkg::FLAG_CY] = 1'b1;
			core_pkg::ALU_ORLC: nxt.status[core_pkg::FLAG_CY] = cy_in | operand[0];
			core_pkg::ALU_ANLC: nxt.status[core_pkg::FLAG_CY] = cy_in & operand[0];
			core_pkg::ALU_ORLNC: nxt.status[core_pkg::FLAG_CY] = cy_in | ~operand[0];
			core_pkg::ALU_ANLNC: nxt.status[core_pkg::FLAG_CY] = cy_in & ~operand[0];
			core_pkg::ALU_MOVC: nxt.status[core_pkg::FLAG_CY] = operand[0];
			core_pkg::ALU_CJNE: nxt.status[core_pkg::FLAG_CY] = (a < operand);
			default: nxt = cur;
		endcase
		// parity always follows the accumulator
		nxt.status[core_pkg::FLAG_P] = ^nxt.acc;
	end

endmodule : core_alu

// ---- verilog/core_timing.sv ----
// Purpose: opcode timing decoder, cycle sequencer and accumulator datapath of the core
// Assumes: opcode, operand and branch outcome are valid together with op_valid
// Notes: architectural state commits when the opcode is taken; done marks the last cycle
`timescale 1ns/1ps
module core_timing #(
	parameter int MAX_CYCLES = core_pkg::MAX_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic [7:0] operand,
	input wire logic branch_taken,
	output logic op_ready,
	output logic done,
	output logic [3:0] cycles_taken,
	output logic [1:0] bytes_taken,
	output logic [7:0] acc,
	output logic [7:0] b_value,
	output logic [7:0] program_status_word,
	output logic [15:0] data_pointer_pair
);

	if (MAX_CYCLES < 8 || MAX_CYCLES > 15) begin : g_bad_max
		$error("MAX_CYCLES must lie between 8 and 15");
	end

	// bytes and clocks of one opcode; cond adds a clock when the branch is taken
	function automatic core_pkg::timing_t op_timing(input logic [7:0] op);
		core_pkg::timing_t t;
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		t.bytes = 2'h1;
		t.cycles = 4'h1;
		t.cond = 1'b0;
		if (lo >= 4'h8) begin
			// register operand column
			case (hi)
				4'h7, 4'h8, 4'hA: t.bytes = 2'h2;
				4'hB: begin
					t.bytes = 2'h3;
					t.cond = 1'b1;
				end
				4'hD: begin
					t.bytes = 2'h2;
					t.cond = 1'b1;
				end
				default: t.bytes = 2'h1;
			endcase
			t.cycles = {2'h0, t.bytes};
		end else if (lo >= 4'h6) begin
			// indirect operand column costs one clock more than its bytes, except high nibbles 7, 8 and A
			case (hi)
				4'h7, 4'h8, 4'hA: t.bytes = 2'h2;
				4'hB: begin
					t.bytes = 2'h3;
					t.cond = 1'b1;
				end
				default: t.bytes = 2'h1;
			endcase
			t.cycles = (hi == 4'hB) ? 4'h4 : 4'h2;
		end else if (lo == 4'h5) begin
			// direct operand column
			case (hi)
				4'h7, 4'h8: t.bytes = 2'h3;
				4'hA: t.bytes = 2'h1;
				4'hB, 4'hD: begin
					t.bytes = 2'h3;
					t.cond = 1'b1;
				end
				default: t.bytes = 2'h2;
			endcase
			t.cycles = {2'h0, t.bytes};
		end else begin
			case (lo)
				4'h4: begin
					case (hi)
						4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: t.cycles = 4'h1;
						4'h8: t.cycles = 4'h8;
						4'hA: t.cycles = 4'h4;
						4'hB: begin
							t.bytes = 2'h3;
							t.cycles = 4'h3;
							t.cond = 1'b1;
						end
						default: begin
							t.bytes = 2'h2;
							t.cycles = 4'h2;
						end
					endcase
				end
				4'h1: begin
					t.bytes = 2'h2;
					t.cycles = 4'h3;
				end
				4'h0: begin
					case (hi)
						4'h0: t.cycles = 4'h1;
						4'h1, 4'h2, 4'h3: begin
							t.bytes = 2'h3;
							t.cycles = 4'h3;
							t.cond = 1'b1;
						end
						4'h4, 4'h5, 4'h6, 4'h7: begin
							t.bytes = 2'h2;
							t.cycles = 4'h2;
							t.cond = 1'b1;
						end
						4'h8: begin
							t.bytes = 2'h2;
							t.cycles = 4'h3;
						end
						4'h9: begin
							t.bytes = 2'h3;
							t.cycles = 4'h3;
						end
						4'hE, 4'hF: t.cycles = 4'h3;
						default: begin
							t.bytes = 2'h2;
							t.cycles = 4'h2;
						end
					endcase
				end
				4'h2: begin
					case (hi)
						4'h0, 4'h1: begin
							t.bytes = 2'h3;
							t.cycles = 4'h4;
						end
						4'h2, 4'h3: t.cycles = 4'h5;
						4'hE, 4'hF: t.cycles = 4'h3;
						default: begin
							t.bytes = 2'h2;
							t.cycles = 4'h2;
						end
					endcase
				end
				default: begin
					case (hi)
						4'h4, 4'h5, 4'h6: begin
							t.bytes = 2'h3;
							t.cycles = 4'h3;
						end
						4'h7, 4'h8, 4'h9, 4'hE, 4'hF: t.cycles = 4'h3;
						default: t.cycles = 4'h1;
					endcase
				end
			endcase
		end
		return t;
	endfunction : op_timing

	// datapath operation of one opcode; moves to memory and writes to memory leave the core state alone
	function automatic core_pkg::alu_op_t alu_sel(input logic [7:0] op);
		core_pkg::alu_op_t s;
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		s = core_pkg::ALU_NONE;
		if (lo >= 4'h4) begin
			case (hi)
				4'h2: s = core_pkg::ALU_ADD;
				4'h3: s = core_pkg::ALU_ADDC;
				4'h4: s = core_pkg::ALU_ORL;
				4'h5: s = core_pkg::ALU_ANL;
				4'h6: s = core_pkg::ALU_XRL;
				4'h9: s = core_pkg::ALU_SUBB;
				4'hE: s = (lo == 4'h4) ? core_pkg::ALU_CLR : core_pkg::ALU_MOV;
				4'hB: s = (lo <= 4'h5) ? core_pkg::ALU_CJNE : core_pkg::ALU_NONE;
				default: s = core_pkg::ALU_NONE;
			endcase
			if (lo == 4'h4) begin
				case (hi)
					4'h0: s = core_pkg::ALU_INC;
					4'h1: s = core_pkg::ALU_DEC;
					4'h7: s = core_pkg::ALU_MOV;
					4'h8: s = core_pkg::ALU_DIV;
					4'hA: s = core_pkg::ALU_MUL;
					4'hC: s = core_pkg::ALU_SWAP;
					4'hD: s = core_pkg::ALU_DA;
					4'hF: s = core_pkg::ALU_CPL;
					default: s = s;
				endcase
			end
		end else if (lo == 4'h3) begin
			case (hi)
				4'h0: s = core_pkg::ALU_RR;
				4'h1: s = core_pkg::ALU_RRC;
				4'h2: s = core_pkg::ALU_RL;
				4'h3: s = core_pkg::ALU_RLC;
				4'hA: s = core_pkg::ALU_INCDP;
				4'hB: s = core_pkg::ALU_CPLC;
				4'hC: s = core_pkg::ALU_CLRC;
				4'hD: s = core_pkg::ALU_SETBC;
				default: s = core_pkg::ALU_NONE;
			endcase
		end else if (lo == 4'h2) begin
			case (hi)
				4'h7: s = core_pkg::ALU_ORLC;
				4'h8: s = core_pkg::ALU_ANLC;
				4'hA: s = core_pkg::ALU_MOVC;
				default: s = core_pkg::ALU_NONE;
			endcase
		end else if (lo == 4'h0) begin
			if (hi == 4'hA) s = core_pkg::ALU_ORLNC;
			if (hi == 4'hB) s = core_pkg::ALU_ANLNC;
		end
		return s;
	endfunction : alu_sel

	logic ready_reg;
	logic done_reg;
	logic [3:0] cnt_reg;
	logic [3:0] cycles_reg;
	logic [1:0] bytes_reg;
	core_pkg::arch_t arch_reg;
	logic [15:0] dpp_reg;
	logic [3:0] elapsed_reg;

	core_pkg::timing_t tim;
	core_pkg::alu_op_t aop;
	core_pkg::arch_t arch_next;
	logic [15:0] dpp_next;
	logic accept;
	logic [3:0] total;
	logic [3:0] cnt_next;
	logic done_next;

	assign tim = op_timing(op_byte);
	assign aop = alu_sel(op_byte);
	assign accept = op_valid && ready_reg;
	assign total = tim.cycles + {3'h0, tim.cond & branch_taken};
	// whole clocks only, held in a plain down counter that any clock rate serves
	assign cnt_next = accept ? total - 4'h1 : ((cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0);
	assign done_next = (accept && total == 4'h1) || (cnt_reg == 4'h1);

	core_alu u_alu (
		.op(aop),
		.cur(arch_reg),
		.operand(operand),
		.pointer(dpp_reg),
		.nxt(arch_next),
		.pointer_next(dpp_next)
	);

	// fully static state: a stopped clock simply holds it
	always_ff @(posedge clk) begin
		if (srst) begin
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			cnt_reg <= 4'h0;
			cycles_reg <= 4'h0;
			bytes_reg <= 2'h0;
			elapsed_reg <= 4'h0;
		end else begin
			ready_reg <= (cnt_next == 4'h0);
			done_reg <= done_next;
			cnt_reg <= cnt_next;
			if (accept) begin
				cycles_reg <= total;
				bytes_reg <= tim.bytes;
			end
			elapsed_reg <= accept ? 4'h1 : ((elapsed_reg == 4'hF) ? 4'hF : elapsed_reg + 4'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			arch_reg <= {core_pkg::ACC_RESET, core_pkg::B_RESET, core_pkg::STATUS_RESET};
			dpp_reg <= core_pkg::DPP_RESET;
		end else if (accept) begin
			arch_reg <= arch_next;
			dpp_reg <= dpp_next;
		end
	end

	assign op_ready = ready_reg;
	assign done = done_reg;
	assign cycles_taken = cycles_reg;
	assign bytes_taken = bytes_reg;
	assign acc = arch_reg.acc;
	assign b_value = arch_reg.b;
	assign program_status_word = arch_reg.status;
	assign data_pointer_pair = dpp_reg;

	a_cycle_count: assert property (@(posedge clk) disable iff (srst) done |-> elapsed_reg == cycles_taken)
		else $error("done does not fall on the counted cycle");
	a_cycle_ceiling: assert property (@(posedge clk) disable iff (srst) cycles_taken <= 4'(MAX_CYCLES))
		else $error("instruction longer than the ceiling");
	a_divide_eight: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_DIV) |-> ##1 (!done)[*7] ##1 done)
		else $error("divide not eight clocks");
	a_single_rate: assert property (@(posedge clk) disable iff (srst)
		(accept && tim.cycles == 4'h1 && !tim.cond) |=> done && op_ready)
		else $error("single clock instruction not back to back");
	a_branch_short: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_JZ && !branch_taken) |-> ##1 !done ##1 done)
		else $error("untaken branch not two clocks");
	a_branch_long: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_JZ && branch_taken) |-> ##1 (!done)[*2] ##1 done)
		else $error("taken branch not three clocks");
	a_add_direct: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_ADD_DIR) |-> ##1 !done ##1 done ##0 bytes_taken == 2'h2)
		else $error("add direct not two clocks");
	a_and_indirect: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_ANL_IND) |-> ##2 done ##0 bytes_taken == 2'h1)
		else $error("and indirect not two clocks");
	a_or_dir_imm: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_ORL_DIR_IMM) |-> ##1 (!done)[*2] ##1 done)
		else $error("or immediate to direct not three clocks");
	a_xor_dir: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_XRL_DIR_A) |-> ##2 done ##0 bytes_taken == 2'h2)
		else $error("xor to direct not two clocks");
	a_multiply_four: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_MUL) |-> ##1 (!done)[*3] ##1 done)
		else $error("multiply not four clocks");
	a_add_result: assert property (@(posedge clk) disable iff (srst)
		(accept && op_byte == core_pkg::OP_ADD_IMM) |=> acc == 8'($past(acc) + $past(operand)))
		else $error("add immediate result wrong");

endmodule : core_timing
